// ---- hw/srq_top.v ----
// Status reporting block: error queue, event registers, enable masks.
// Assumes a decoder on this clock that delivers one op per cycle,
// and a non-volatile store that holds the mask and flag values.
`timescale 1ns/10ps
`include "srq_regs.vh"
module srq_top #(
  parameter BEEP_MS     = `SRQ_BEEP_MS,
  parameter CLK_MHZ     = `SRQ_CLK_MHZ,
  parameter BEEP_CYCLES = BEEP_MS * CLK_MHZ * 1000,
  parameter TCHARS      = `SRQ_TEXT_CHARS,
  parameter TW          = 8 * TCHARS
) (
  input  wire          i_clk_sys,
  input  wire          i_sys_rst,
  input  wire          i_cmd_valid,
  input  wire [4:0]    i_cmd_op,
  input  wire [15:0]   i_cmd_data,
  input  wire          i_err_valid,
  input  wire [15:0]   i_err_code,
  input  wire [TW-1:0] i_err_text,
  input  wire [15:0]   i_ques_evt,
  input  wire [7:0]    i_std_evt,
  input  wire          i_nv_psc,
  input  wire [7:0]    i_nv_sre,
  input  wire [7:0]    i_nv_ese,
  output reg           o_ready,
  output reg           o_rsp_valid,
  output reg  [15:0]   o_rsp_value,
  output reg  [TW-1:0] o_rsp_text,
  output reg  [7:0]    o_stb,
  output wire          o_beep,
  output reg           o_nv_wr,
  output reg           o_nv_psc,
  output reg  [7:0]    o_nv_sre,
  output reg  [7:0]    o_nv_ese
);
  reg  [15:0]   ques_enable_mask_reg;
  reg  [15:0]   ques_event_flags_reg;
  reg  [7:0]    std_enable_mask_reg;
  reg  [7:0]    std_event_flags_reg;
  reg  [7:0]    sre_mask_reg;
  reg           psc_flag_reg;
  reg           err_beep_reg;
  reg           init_reg;
  reg  [15:0]   ques_event_next;
  reg  [7:0]    std_event_next;
  reg  [7:0]    stb_next;
  wire          cmd;
  wire          cls;
  wire          q_empty;
  wire          q_full;
  wire [15:0]   q_code;
  wire [TW-1:0] q_text;
  wire          q_pop;
  wire [TW-1:0] noerr_text;

  assign cmd = i_cmd_valid & ~init_reg;
  assign cls = cmd & (i_cmd_op == `SRQ_OP_CLS);
  assign q_pop = cmd & (i_cmd_op == `SRQ_OP_ERR_Q);

  // Characters packed first-in-low; unused bytes stay zero
  assign noerr_text = {{(TW-64){1'b0}}, 64'h726F727265206F4E};

  srq_err_fifo #(
    .DEPTH (`SRQ_QUEUE_DEPTH),
    .AW    (4),
    .CW    (16),
    .TW    (TW)
  ) u_queue (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_clear   (cls),
    .i_push    (i_err_valid),
    .i_code    (i_err_code),
    .i_text    (i_err_text),
    .i_pop     (q_pop),
    .o_empty   (q_empty),
    .o_full    (q_full),
    .o_code    (q_code),
    .o_text    (q_text)
  );

  srq_beep #(
    .BEEP_CYCLES (BEEP_CYCLES),
    .CNTW        (32)
  ) u_beep (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_trigger (i_err_valid & err_beep_reg),
    .o_beep    (o_beep)
  );

  // Event flags: a new event in the clearing cycle survives the clear
  always @* begin
    ques_event_next = ques_event_flags_reg;
    std_event_next  = std_event_flags_reg;
    if (cls) begin
      ques_event_next = 16'h0000;
      std_event_next  = 8'h00;
    end
    ques_event_next = ques_event_next
                    | (i_ques_evt & `SRQ_QUES_USED);
    std_event_next  = std_event_next
                    | (i_std_evt & `SRQ_ESE_USED);
    if (cmd && i_cmd_op == `SRQ_OP_OPC)
      std_event_next[`SRQ_ESR_OPC_BIT] = 1'b1;
  end

  // Status byte follows the flags; it clears with them
  always @* begin
    stb_next = 8'h00;
    stb_next[`SRQ_STB_ERR_BIT] = ~q_empty & ~cls;
    stb_next[`SRQ_STB_QUE_BIT] =
      |(ques_event_flags_reg & ques_enable_mask_reg & `SRQ_QUES_USED);
    stb_next[`SRQ_STB_ESB_BIT] =
      |(std_event_flags_reg & std_enable_mask_reg & `SRQ_ESE_USED);
    if (cls) begin
      stb_next[`SRQ_STB_QUE_BIT] = 1'b0;
      stb_next[`SRQ_STB_ESB_BIT] = 1'b0;
    end
    stb_next[`SRQ_STB_MSS_BIT] =
      |(stb_next & sre_mask_reg & `SRQ_SRE_USED);
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ques_event_flags_reg <= 16'h0000;
      std_event_flags_reg  <= 8'h00;
      o_stb                <= 8'h00;
    end else begin
      ques_event_flags_reg <= ques_event_next;
      std_event_flags_reg  <= std_event_next;
      o_stb                <= stb_next;
    end
  end

  // Configuration and power-up handling
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      init_reg             <= 1'b1;
      o_ready              <= 1'b0;
      ques_enable_mask_reg <= `SRQ_QENA_RST;
      std_enable_mask_reg  <= `SRQ_MASK8_RST;
      sre_mask_reg         <= `SRQ_MASK8_RST;
      psc_flag_reg         <= 1'b0;
      err_beep_reg         <= 1'b0;
      o_nv_wr              <= 1'b0;
      o_nv_psc             <= 1'b0;
      o_nv_sre             <= 8'h00;
      o_nv_ese             <= 8'h00;
    end else if (init_reg) begin
      // Straps are taken one cycle after release, never under reset
      init_reg     <= 1'b0;
      o_ready      <= 1'b1;
      psc_flag_reg <= i_nv_psc;
      o_nv_psc     <= i_nv_psc;
      if (i_nv_psc) begin
        std_enable_mask_reg <= `SRQ_MASK8_RST;
        sre_mask_reg        <= `SRQ_MASK8_RST;
        o_nv_sre            <= `SRQ_MASK8_RST;
        o_nv_ese            <= `SRQ_MASK8_RST;
        o_nv_wr             <= 1'b1;
      end else begin
        std_enable_mask_reg <= i_nv_ese;
        sre_mask_reg        <= i_nv_sre;
        o_nv_sre            <= i_nv_sre;
        o_nv_ese            <= i_nv_ese;
      end
    end else begin
      o_nv_wr <= 1'b0;
      if (cmd) begin
        case (i_cmd_op)
          `SRQ_OP_EBEEP_W: begin
            err_beep_reg <= i_cmd_data[0];
          end
          `SRQ_OP_QENA_W: begin
            ques_enable_mask_reg <= i_cmd_data;
          end
          `SRQ_OP_PRESET: begin
            ques_enable_mask_reg <= `SRQ_QENA_RST;
          end
          `SRQ_OP_ESE_W: begin
            std_enable_mask_reg <= i_cmd_data[7:0];
            o_nv_ese            <= i_cmd_data[7:0];
            o_nv_wr             <= 1'b1;
          end
          `SRQ_OP_SRE_W: begin
            sre_mask_reg <= i_cmd_data[7:0];
            o_nv_sre     <= i_cmd_data[7:0];
            o_nv_wr      <= 1'b1;
          end
          `SRQ_OP_PSC_W: begin
            psc_flag_reg <= i_cmd_data[0];
            o_nv_psc     <= i_cmd_data[0];
            o_nv_wr      <= 1'b1;
          end
          default: begin
            o_nv_wr <= 1'b0;
          end
        endcase
      end
    end
  end

  // Query answers, one cycle after the op
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_value <= 16'h0000;
      o_rsp_text  <= {TW{1'b0}};
    end else begin
      o_rsp_valid <= 1'b0;
      if (cmd) begin
        o_rsp_text <= {TW{1'b0}};
        case (i_cmd_op)
          `SRQ_OP_ERR_Q: begin
            o_rsp_valid <= 1'b1;
            if (q_empty) begin
              o_rsp_value <= `SRQ_NOERR_CODE;
              o_rsp_text  <= noerr_text;
            end else begin
              o_rsp_value <= q_code;
              o_rsp_text  <= q_text;
            end
          end
          `SRQ_OP_EBEEP_Q: begin
            o_rsp_valid <= 1'b1;
            o_rsp_value <= {15'h0000, err_beep_reg};
          end
          `SRQ_OP_QENA_Q: begin
            o_rsp_valid <= 1'b1;
            o_rsp_value <= ques_enable_mask_reg;
          end
          `SRQ_OP_QEVT_Q: begin
            o_rsp_valid <= 1'b1;
            o_rsp_value <= ques_event_flags_reg;
          end
          `SRQ_OP_ESE_Q: begin
            o_rsp_valid <= 1'b1;
            o_rsp_value <= {8'h00, std_enable_mask_reg};
          end
          `SRQ_OP_ESR_Q: begin
            o_rsp_valid <= 1'b1;
            o_rsp_value <= {8'h00, std_event_flags_reg};
          end
          `SRQ_OP_OPC_Q: begin
            o_rsp_valid <= 1'b1;
            o_rsp_value <= `SRQ_OPC_ANSWER;
          end
          `SRQ_OP_PSC_Q: begin
            o_rsp_valid <= 1'b1;
            o_rsp_value <= {15'h0000, psc_flag_reg};
          end
          `SRQ_OP_SRE_Q: begin
            o_rsp_valid <= 1'b1;
            o_rsp_value <= {8'h00, sre_mask_reg};
          end
          `SRQ_OP_STB_Q: begin
            o_rsp_valid <= 1'b1;
            o_rsp_value <= {8'h00, o_stb};
          end
          default: begin
            o_rsp_valid <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ---- hw/srq_regs.vh ----
// Constants for the status reporting and error queue block.
// Assumes a command decoder outside that turns host messages into ops.
// What this block does
// - Error queries return oldest queued error, then drop it
// - Queue holds sixteen; extra errors dropped while full
// - Each queued error carries up to 80 characters
// - Empty queue query answers code zero, No error
// - Error-beep setting one sounds beeper on errors
// - Questionable mask takes 16 bits; six bits functional
// - Questionable event query; only six bits ever set
// - Status preset zeroes questionable enable mask
// - Clear-status zeroes status byte, events, error queue
// - Standard mask 8 bits; bits 0,2-5,7 functional
// - Standard event query returns set event bits
// - Operation-complete command sets standard event bit 0
// - Operation-complete query answers value one
// - Flag zero keeps enable masks across power-up
// - Flag one clears both enable masks at power-up
// - Status byte mask 8 bits; bits 3-5 functional
`ifndef SRQ_REGS_VH
`define SRQ_REGS_VH

`define SRQ_OP_NOP      5'h00
`define SRQ_OP_ERR_Q    5'h01
`define SRQ_OP_EBEEP_W  5'h02
`define SRQ_OP_EBEEP_Q  5'h03
`define SRQ_OP_QENA_W   5'h04
`define SRQ_OP_QENA_Q   5'h05
`define SRQ_OP_QEVT_Q   5'h06
`define SRQ_OP_PRESET   5'h07
`define SRQ_OP_CLS      5'h08
`define SRQ_OP_ESE_W    5'h09
`define SRQ_OP_ESE_Q    5'h0A
`define SRQ_OP_ESR_Q    5'h0B
`define SRQ_OP_OPC      5'h0C
`define SRQ_OP_OPC_Q    5'h0D
`define SRQ_OP_PSC_W    5'h0E
`define SRQ_OP_PSC_Q    5'h0F
`define SRQ_OP_SRE_W    5'h10
`define SRQ_OP_SRE_Q    5'h11
`define SRQ_OP_STB_Q    5'h12

`define SRQ_QUES_USED   16'h3A03
`define SRQ_ESE_USED    8'hBD
`define SRQ_SRE_USED    8'h38
`define SRQ_ESR_OPC_BIT 0
`define SRQ_STB_ERR_BIT 2
`define SRQ_STB_QUE_BIT 3
`define SRQ_STB_ESB_BIT 5
`define SRQ_STB_MSS_BIT 6
`define SRQ_QENA_RST    16'h0000
`define SRQ_MASK8_RST   8'h00
`define SRQ_NOERR_CODE  16'h0000
`define SRQ_OPC_ANSWER  16'h0001
`define SRQ_TEXT_CHARS  80
`define SRQ_QUEUE_DEPTH 16
`define SRQ_BEEP_MS     100
`define SRQ_CLK_MHZ     100

`endif

// ---- hw/srq_err_fifo.v ----
// First-in first-out store of error codes with their message text.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/10ps
module srq_err_fifo #(
  parameter DEPTH = 16,
  parameter AW    = 4,
  parameter CW    = 16,
  parameter TW    = 640
) (
  input  wire          i_clk_sys,
  input  wire          i_sys_rst,
  input  wire          i_clear,
  input  wire          i_push,
  input  wire [CW-1:0] i_code,
  input  wire [TW-1:0] i_text,
  input  wire          i_pop,
  output wire          o_empty,
  output wire          o_full,
  output wire [CW-1:0] o_code,
  output wire [TW-1:0] o_text
);
  reg [CW-1:0] code_mem [0:DEPTH-1];
  reg [TW-1:0] text_mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0]   count_reg;
  wire         do_push;
  wire         do_pop;

  assign o_empty = (count_reg == {(AW+1){1'b0}});
  assign o_full  = (count_reg == DEPTH[AW:0]);
  // New errors are lost while full, never overwrite queued ones
  // A clear in the same cycle makes room, so the new error is kept
  assign do_push = i_push & (~o_full | i_clear);
  assign do_pop  = i_pop & ~o_empty;
  assign o_code  = code_mem[rd_ptr_reg];
  assign o_text  = text_mem[rd_ptr_reg];

  always @(posedge i_clk_sys) begin
    if (do_push) begin
      code_mem[i_clear ? {AW{1'b0}} : wr_ptr_reg] <= i_code;
      text_mem[i_clear ? {AW{1'b0}} : wr_ptr_reg] <= i_text;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else if (i_clear) begin
      wr_ptr_reg <= {{(AW-1){1'b0}}, do_push};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {{AW{1'b0}}, do_push};
    end else begin
      if (do_push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (do_push && !do_pop)
        count_reg <= count_reg + 1'b1;
      else if (do_pop && !do_push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule

// ---- hw/srq_beep.v ----
// Beeper pulse stretcher: one trigger holds the beeper on a fixed time.
// Assumes a beeper driver that sounds while its enable is high.
`timescale 1ns/10ps
module srq_beep #(
  parameter BEEP_CYCLES = 10000000,
  parameter CNTW        = 24
) (
  input  wire i_clk_sys,
  input  wire i_sys_rst,
  input  wire i_trigger,
  output reg  o_beep
);
  reg [CNTW-1:0] cnt_reg;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cnt_reg <= {CNTW{1'b0}};
      o_beep  <= 1'b0;
    end else if (i_trigger) begin
      // A fresh error restarts the tone rather than queueing another
      cnt_reg <= BEEP_CYCLES[CNTW-1:0] - 1'b1;
      o_beep  <= 1'b1;
    end else if (cnt_reg != {CNTW{1'b0}}) begin
      cnt_reg <= cnt_reg - 1'b1;
    end else begin
      o_beep  <= 1'b0;
    end
  end
endmodule

// ---- tb/srq_top_props.sv ----
// Port checker for the status block: answers, stores, status byte.
// Assumes it is bound onto srq_top and sees only that module's ports.
`timescale 1ns/10ps
`include "srq_regs.vh"
module srq_top_chk (
  input wire        i_clk_sys,
  input wire        i_sys_rst,
  input wire        i_cmd_valid,
  input wire [4:0]  i_cmd_op,
  input wire [15:0] i_cmd_data,
  input wire        i_err_valid,
  input wire [15:0] i_ques_evt,
  input wire [7:0]  i_std_evt,
  input wire        i_nv_psc,
  input wire        o_ready,
  input wire        o_rsp_valid,
  input wire [15:0] o_rsp_value,
  input wire [7:0]  o_stb,
  input wire        o_nv_wr,
  input wire [7:0]  o_nv_sre,
  input wire [7:0]  o_nv_ese
);
  wire tk   = i_cmd_valid & o_ready;
  // Events arriving with a clear win, so they must be absent to expect zero
  wire calm = !i_err_valid && i_ques_evt == 16'h0000 && i_std_evt == 8'h00;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  AST_OPC_ANS: assert property (tk && i_cmd_op == `SRQ_OP_OPC_Q |=>
    o_rsp_valid && o_rsp_value == 16'h0001) else $error("opc answer");
  AST_QEVT_BITS: assert property (tk && i_cmd_op == `SRQ_OP_QEVT_Q |=>
    o_rsp_valid && (o_rsp_value & 16'hC5FC) == 16'h0000)
    else $error("ques bits");
  AST_ESR_BITS: assert property (tk && i_cmd_op == `SRQ_OP_ESR_Q |=>
    o_rsp_valid && (o_rsp_value & 16'hFF42) == 16'h0000)
    else $error("std bits");
  AST_ESE_STORE: assert property (tk && i_cmd_op == `SRQ_OP_ESE_W |=>
    o_nv_wr && !o_rsp_valid && o_nv_ese == $past(i_cmd_data[7:0]))
    else $error("ese store");
  AST_SRE_STORE: assert property (tk && i_cmd_op == `SRQ_OP_SRE_W |=>
    o_nv_wr && o_nv_sre == $past(i_cmd_data[7:0])) else $error("sre store");
  AST_PSC_CLEAR: assert property ($past(i_sys_rst) && i_nv_psc |=>
    o_nv_wr && o_nv_sre == 8'h00 && o_nv_ese == 8'h00)
    else $error("power-up clear");
  AST_ERR_STB: assert property (i_err_valid && o_ready &&
    !(tk && i_cmd_op == `SRQ_OP_CLS) |-> ##[1:2] o_stb[2])
    else $error("queue flag");
  AST_CLS_STB: assert property (tk && i_cmd_op == `SRQ_OP_CLS && calm
    ##1 calm && !i_cmd_valid |=> o_stb == 8'h00) else $error("clear stb");
  AST_PRESET: assert property (tk && i_cmd_op == `SRQ_OP_PRESET ##1
    !tk ##1 tk && i_cmd_op == `SRQ_OP_QENA_Q |=> o_rsp_value == 16'h0000)
    else $error("preset");
  cover property (tk && i_cmd_op == `SRQ_OP_ERR_Q && o_stb[2]);
  cover property (tk && i_cmd_op == `SRQ_OP_CLS && o_stb[2]);
  cover property (i_err_valid && o_stb[2]);
endmodule
bind srq_top srq_top_chk u_chk (.i_clk_sys, .i_sys_rst, .i_cmd_valid,
  .i_cmd_op, .i_cmd_data, .i_err_valid, .i_ques_evt, .i_std_evt, .i_nv_psc,
  .o_ready, .o_rsp_valid, .o_rsp_value, .o_stb, .o_nv_wr, .o_nv_sre,
  .o_nv_ese);

// ---- tb/srq_host.sv ----
// Remote host model: one op at a time on the command port.
// Assumes the block answers a query one cycle after taking it.
`timescale 1ns/10ps
module srq_host #(
  parameter TW = 640
) (
  input  wire          i_clk_sys,
  input  wire          i_rsp_valid,
  input  wire [15:0]   i_rsp_value,
  input  wire [TW-1:0] i_rsp_text,
  output reg           o_cmd_valid,
  output reg  [4:0]    o_cmd_op,
  output reg  [15:0]   o_cmd_data
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_op    = 5'h00;
    o_cmd_data  = 16'h0000;
  end
  task send(input [4:0] op, input [15:0] d, output ok, output [15:0] v,
            output [TW-1:0] t);
    begin
      @(negedge i_clk_sys);
      o_cmd_valid = 1'b1;
      o_cmd_op    = op;
      o_cmd_data  = d;
      @(negedge i_clk_sys);
      ok          = i_rsp_valid;
      v           = i_rsp_value;
      t           = i_rsp_text;
      o_cmd_valid = 1'b0;
      // Idle lines change so a stale op can never pass for a live one
      o_cmd_op    = ~op;
      o_cmd_data  = ~d;
    end
  endtask
endmodule

// ---- tb/tb_status_report_error_queue.sv ----
// Testbench: host model, non-volatile store and error source.
// Assumes the checker is bound to the block by its own file.
`timescale 1ns/10ps
`include "srq_regs.vh"
module tb_status_report_error_queue;
  localparam TW = 640;
  reg           clk, rst, err_v, psc, ok;
  reg  [15:0]   err_c, qevt, v;
  reg  [7:0]    sevt, sre, ese;
  reg  [TW-1:0] err_t, t;
  wire          valid, rdy, rv, beep, nvw, nvp;
  wire [4:0]    op;
  wire [15:0]   data, rval;
  wire [TW-1:0] rtext;
  wire [7:0]    stb, nsre, nese;
  integer       error_cnt, samples_checked, i;
  srq_top #(.BEEP_CYCLES(8)) dut (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_cmd_valid(valid), .i_cmd_op(op), .i_cmd_data(data),
    .i_err_valid(err_v), .i_err_code(err_c), .i_err_text(err_t),
    .i_ques_evt(qevt), .i_std_evt(sevt), .i_nv_psc(psc), .i_nv_sre(sre),
    .i_nv_ese(ese), .o_ready(rdy), .o_rsp_valid(rv), .o_rsp_value(rval),
    .o_rsp_text(rtext), .o_stb(stb), .o_beep(beep), .o_nv_wr(nvw),
    .o_nv_psc(nvp), .o_nv_sre(nsre), .o_nv_ese(nese));
  srq_host host (.i_clk_sys(clk), .i_rsp_valid(rv), .i_rsp_value(rval),
    .i_rsp_text(rtext), .o_cmd_valid(valid), .o_cmd_op(op),
    .o_cmd_data(data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Non-volatile store keeps whatever the block last asked it to hold
  always @(negedge clk) begin
    if (nvw) begin
      psc <= nvp;
      sre <= nsre;
      ese <= nese;
    end
  end
  task chk_v(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("Error %0t: value %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_t(input [TW-1:0] got, input [TW-1:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("Error %0t: error text differs", $time);
      end
    end
  endtask
  task w(input [4:0] o, input [15:0] d);
    begin
      host.send(o, d, ok, v, t);
      chk_v({15'h0000, ok}, 16'h0000);
    end
  endtask
  task q(input [4:0] o, input [15:0] e);
    begin
      host.send(o, 16'h0000, ok, v, t);
      chk_v({15'h0000, ok}, 16'h0001);
      chk_v(v, e);
    end
  endtask
  task end_of_test;
    begin
      $display("Checks %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task do_reset;
    begin
      rst = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      i = 0;
      while (rdy !== 1'b1 && i < 10) begin
        @(negedge clk);
        i = i + 1;
      end
      chk_v({15'h0000, rdy}, 16'h0001);
      if (i == 10)
        end_of_test;
    end
  endtask
  initial begin
    #1000000;
    error_cnt = error_cnt + 1;
    end_of_test;
  end
  initial begin
    rst = 1'b1;
    err_v = 1'b0;
    err_c = 16'h0000;
    err_t = {TW{1'b0}};
    qevt = 16'h0000;
    sevt = 8'h00;
    psc = 1'b0;
    sre = 8'h00;
    ese = 8'h00;
    error_cnt = 0;
    samples_checked = 0;
    do_reset;
    w(`SRQ_OP_PSC_W, 16'h0000);
    w(`SRQ_OP_SRE_W, 16'h0028);
    w(`SRQ_OP_ESE_W, 16'h0081);
    do_reset;
    q(`SRQ_OP_SRE_Q, 16'h0028);
    q(`SRQ_OP_ESE_Q, 16'h0081);
    w(`SRQ_OP_PSC_W, 16'h0001);
    do_reset;
    q(`SRQ_OP_SRE_Q, 16'h0000);
    q(`SRQ_OP_ESE_Q, 16'h0000);
    q(`SRQ_OP_PSC_Q, 16'h0001);
    w(`SRQ_OP_QENA_W, 16'hFFFF);
    q(`SRQ_OP_QENA_Q, 16'hFFFF);
    w(`SRQ_OP_PRESET, 16'h0000);
    q(`SRQ_OP_QENA_Q, 16'h0000);
    w(`SRQ_OP_ESE_W, 16'h00FF);
    q(`SRQ_OP_ESE_Q, 16'h00FF);
    w(`SRQ_OP_SRE_W, 16'h00FF);
    q(`SRQ_OP_SRE_Q, 16'h00FF);
    w(`SRQ_OP_EBEEP_W, 16'h0001);
    q(`SRQ_OP_EBEEP_Q, 16'h0001);
    @(negedge clk);
    qevt = 16'hFFFF;
    sevt = 8'hFE;
    @(negedge clk);
    qevt = 16'h0000;
    sevt = 8'h00;
    q(`SRQ_OP_QEVT_Q, 16'h3A03);
    q(`SRQ_OP_ESR_Q, 16'h00BC);
    q(`SRQ_OP_ESR_Q, 16'h00BC);
    // Standard summary and its request bit; the question mask is preset
    q(`SRQ_OP_STB_Q, 16'h0060);
    w(`SRQ_OP_OPC, 16'h0000);
    q(`SRQ_OP_ESR_Q, 16'h00BD);
    q(`SRQ_OP_OPC_Q, 16'h0001);
    for (i = 1; i <= 17; i = i + 1) begin
      @(negedge clk);
      err_v = 1'b1;
      err_c = i[15:0];
      err_t = {40{i[15:0]}};
    end
    @(negedge clk);
    err_v = 1'b0;
    chk_v({15'h0000, beep}, 16'h0001);
    for (i = 1; i <= 16; i = i + 1) begin
      host.send(`SRQ_OP_ERR_Q, 16'h0000, ok, v, t);
      chk_v(v, i[15:0]);
      chk_t(t, {40{i[15:0]}});
    end
    q(`SRQ_OP_ERR_Q, 16'h0000);
    chk_t(t, {576'h0, 64'h726F727265206F4E});
    w(`SRQ_OP_EBEEP_W, 16'h0000);
    @(negedge clk);
    err_v = 1'b1;
    qevt = 16'h0001;
    @(negedge clk);
    err_v = 1'b0;
    qevt = 16'h0000;
    chk_v({15'h0000, beep}, 16'h0000);
    w(`SRQ_OP_CLS, 16'h0000);
    repeat (2) @(negedge clk);
    chk_v({8'h00, stb}, 16'h0000);
    q(`SRQ_OP_ERR_Q, 16'h0000);
    q(`SRQ_OP_ESR_Q, 16'h0000);
    q(`SRQ_OP_QEVT_Q, 16'h0000);
    end_of_test;
  end
endmodule
